// file: design/lbc_top.sv
// LED boost control registers with two-wire serial slave
//
// Functional notes
// - Regulator on if pushbutton low, or enable pin high with enable bit set.
// - Byte 42h bit 0 is read/write enable request; 1 enables.
// - Byte 42h bit 1 reads power good; cleared when sense exceeds threshold.
// - Bytes 40h, 41h, 42h[7:3], 43h[7:6] are read-only.
// - Byte 43h bits 5:0 are read/write over-voltage threshold code.
// - Threshold: 5V+2V*[4:3]+0.25V*[2:0], or 13V+4V*[4:3]+0.5V*[2:0].
// - Threshold code resets to the highest code, 28.5 V.
// - At threshold, regulator limits output instead of regulating current.
// - Host reads power good over the two-wire serial interface.
`timescale 1ns/1ps
module lbc_top (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_b,
    input  wire logic        pushbutton_in_n,
    input  wire logic        regulator_enable_pin,
    input  wire logic [11:0] string_top_sense,
    output logic             led_boost_regulator_en,
    output logic             overvoltage_protection,
    output logic [11:0]      ovp_threshold_q
);
    import lbc_pkg::*;

    // ------------------------------------------------------------
    // Line edges
    // ------------------------------------------------------------
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    logic start_ev;
    logic stop_ev;

    lbc_edge u_scl (
        .clk     (clk),
        .rst_b   (rst_b),
        .line_in (scl_in),
        .level   (scl_lvl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    lbc_edge u_sda (
        .clk     (clk),
        .rst_b   (rst_b),
        .line_in (sda_in),
        .level   (sda_lvl),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    assign start_ev = scl_lvl & sda_fall;
    assign stop_ev  = scl_lvl & sda_rise;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic       on_q;
    logic       on_d;
    logic       wexact_q;
    logic       wexact_d;
    logic [5:0] code_q;
    logic [5:0] code_d;
    logic       pgood_q;
    logic       pgood_d;
    logic       en_q;
    logic       en_d;
    logic       ovp_over;
    logic       ovp_limit;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] enable_byte;
    logic [7:0] ovp_byte;
    logic       wr_enable_sel;
    logic       wr_ovp_sel;

    lbc_ovp u_ovp (
        .clk                (clk),
        .rst_b              (rst_b),
        .ovp_threshold_code (code_q),
        .string_top_sense   (string_top_sense),
        .threshold_q        (ovp_threshold_q),
        .over_q             (ovp_over),
        .limit_q            (ovp_limit)
    );

    // ------------------------------------------------------------
    // Read byte assembly
    // ------------------------------------------------------------
    always_comb begin
        enable_byte                 = 8'h00;
        enable_byte[LBC_BIT_ON]     = on_q;
        enable_byte[LBC_BIT_PGOOD]  = pgood_q;
        enable_byte[LBC_BIT_WEXACT] = wexact_q;
        ovp_byte                    = 8'h00;
        ovp_byte[LBC_OVP_RANGE:0]   = code_q;
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (rd_addr)
            LBC_ADDR_RSVD_A: rd_data = LBC_RSVD_A_VAL;
            LBC_ADDR_RSVD_B: rd_data = LBC_RSVD_B_VAL;
            LBC_ADDR_ENABLE: rd_data = enable_byte;
            LBC_ADDR_OVP:    rd_data = ovp_byte;
            default:         rd_data = LBC_UNMAPPED_VAL;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes and status
    // ------------------------------------------------------------
    assign wr_enable_sel = wr_en && (wr_addr == LBC_ADDR_ENABLE);
    assign wr_ovp_sel    = wr_en && (wr_addr == LBC_ADDR_OVP);

    always_comb begin
        on_d     = on_q;
        wexact_d = wexact_q;
        code_d   = code_q;
        if (wr_enable_sel) begin
            on_d     = wr_data[LBC_BIT_ON];
            wexact_d = wr_data[LBC_BIT_WEXACT];
        end
        if (wr_ovp_sel) begin
            code_d = wr_data[LBC_OVP_RANGE:0];
        end
        pgood_d = ~ovp_over;
        en_d    = ~pushbutton_in_n | (regulator_enable_pin & on_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            on_q     <= LBC_ON_RST;
            wexact_q <= LBC_WEXACT_RST;
            code_q   <= LBC_OVP_CODE_RST;
            pgood_q  <= 1'b0;
            en_q     <= 1'b0;
        end else begin
            on_q     <= on_d;
            wexact_q <= wexact_d;
            code_q   <= code_d;
            pgood_q  <= pgood_d;
            en_q     <= en_d;
        end
    end

    assign led_boost_regulator_en = en_q;
    assign overvoltage_protection = ovp_limit;

    // ------------------------------------------------------------
    // Serial slave state
    // ------------------------------------------------------------
    lbc_state_t state_q;
    lbc_state_t state_d;
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic       oe_b_q;
    logic       oe_b_d;
    logic       rw_q;
    logic       rw_d;
    logic       addr_match;

    assign rd_addr = ptr_q;
    assign wr_addr = ptr_q;
    assign wr_data = shreg_q;
    assign sda_out = 1'b0;
    assign sda_oe_b = oe_b_q;
    assign addr_match = (shreg_q[7:1] == LBC_SLAVE_ADDR);

    // ------------------------------------------------------------
    // Byte framing and acknowledge
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        shreg_d = shreg_q;
        cnt_d   = cnt_q;
        ptr_d   = ptr_q;
        oe_b_d  = oe_b_q;
        rw_d    = rw_q;
        wr_en   = 1'b0;
        if (start_ev) begin
            state_d = LBC_ST_ADDR;
            cnt_d   = 4'h0;
            oe_b_d  = 1'b1;
        end else if (stop_ev) begin
            state_d = LBC_ST_IDLE;
            oe_b_d  = 1'b1;
        end else begin
            case (state_q)
                LBC_ST_IDLE: begin
                    oe_b_d = 1'b1;
                end
                LBC_ST_ADDR, LBC_ST_PTR, LBC_ST_WDATA: begin
                    if (scl_rise && cnt_q != LBC_BITS_PER_BYTE) begin
                        shreg_d = {shreg_q[6:0], sda_lvl};
                        cnt_d   = 4'(cnt_q + 4'h1);
                    end else if (scl_fall && cnt_q == LBC_BITS_PER_BYTE) begin
                        cnt_d  = 4'h0;
                        oe_b_d = 1'b0;
                        if (state_q == LBC_ST_ADDR) begin
                            if (addr_match) begin
                                state_d = LBC_ST_AACK;
                                rw_d    = shreg_q[0];
                            end else begin
                                state_d = LBC_ST_IDLE;
                                oe_b_d  = 1'b1;
                            end
                        end else if (state_q == LBC_ST_PTR) begin
                            state_d = LBC_ST_PACK;
                            ptr_d   = shreg_q;
                        end else begin
                            state_d = LBC_ST_WACK;
                            wr_en   = 1'b1;
                            ptr_d   = 8'(ptr_q + 8'h01);
                        end
                    end
                end
                LBC_ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            state_d = LBC_ST_RDATA;
                            shreg_d = rd_data;
                            oe_b_d  = rd_data[7];
                            ptr_d   = 8'(ptr_q + 8'h01);
                        end else begin
                            state_d = LBC_ST_PTR;
                            oe_b_d  = 1'b1;
                        end
                    end
                end
                LBC_ST_PACK, LBC_ST_WACK: begin
                    if (scl_fall) begin
                        state_d = LBC_ST_WDATA;
                        oe_b_d  = 1'b1;
                    end
                end
                LBC_ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'(LBC_BITS_PER_BYTE - 4'h1)) begin
                            state_d = LBC_ST_RACK;
                            cnt_d   = 4'h0;
                            oe_b_d  = 1'b1;
                        end else begin
                            shreg_d = {shreg_q[6:0], 1'b0};
                            cnt_d   = 4'(cnt_q + 4'h1);
                            oe_b_d  = shreg_q[6];
                        end
                    end
                end
                LBC_ST_RACK: begin
                    if (scl_rise && sda_lvl) begin
                        state_d = LBC_ST_IDLE;
                    end else if (scl_fall) begin
                        state_d = LBC_ST_RDATA;
                        shreg_d = rd_data;
                        oe_b_d  = rd_data[7];
                        ptr_d   = 8'(ptr_q + 8'h01);
                    end
                end
                default: begin
                    state_d = LBC_ST_IDLE;
                    oe_b_d  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= LBC_ST_IDLE;
            shreg_q <= 8'h00;
            cnt_q   <= 4'h0;
            ptr_q   <= 8'h00;
            oe_b_q  <= 1'b1;
            rw_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            cnt_q   <= cnt_d;
            ptr_q   <= ptr_d;
            oe_b_q  <= oe_b_d;
            rw_q    <= rw_d;
        end
    end

endmodule : lbc_top

// file: design/lbc_pkg.sv
// Package of constants for the LED boost control register bank
package lbc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] LBC_ADDR_RSVD_A   = 8'h40;
    localparam logic [7:0] LBC_ADDR_RSVD_B   = 8'h41;
    localparam logic [7:0] LBC_ADDR_ENABLE   = 8'h42;
    localparam logic [7:0] LBC_ADDR_OVP      = 8'h43;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int         LBC_BIT_ON        = 0;
    localparam int         LBC_BIT_PGOOD     = 1;
    localparam int         LBC_BIT_WEXACT    = 2;
    localparam int         LBC_OVP_RANGE     = 5;
    localparam int         LBC_OVP_COARSE_HI = 4;
    localparam int         LBC_OVP_COARSE_LO = 3;
    localparam int         LBC_OVP_FINE_HI   = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       LBC_ON_RST        = 1'b0;
    localparam logic       LBC_WEXACT_RST    = 1'b0;
    localparam logic [5:0] LBC_OVP_CODE_RST  = 6'h3f;
    localparam logic [7:0] LBC_RSVD_A_VAL    = 8'h00;
    localparam logic [7:0] LBC_RSVD_B_VAL    = 8'h00;
    localparam logic [7:0] LBC_UNMAPPED_VAL  = 8'h00;

    // ------------------------------------------------------------
    // Threshold arithmetic, units of 10 mV
    // ------------------------------------------------------------
    localparam int         LBC_MV_W          = 12;
    localparam logic [11:0] LBC_LO_BASE      = 12'h1f4;
    localparam logic [11:0] LBC_LO_COARSE    = 12'h0c8;
    localparam logic [11:0] LBC_LO_FINE      = 12'h019;
    localparam logic [11:0] LBC_HI_BASE      = 12'h514;
    localparam logic [11:0] LBC_HI_COARSE    = 12'h190;
    localparam logic [11:0] LBC_HI_FINE      = 12'h032;

    // ------------------------------------------------------------
    // Serial interface
    // ------------------------------------------------------------
    // Slave address value is arbitrary
    localparam logic [6:0] LBC_SLAVE_ADDR    = 7'h5a;
    localparam logic [3:0] LBC_BITS_PER_BYTE = 4'h8;

    typedef enum logic [8:0] {
        LBC_ST_IDLE  = 9'h001,
        LBC_ST_ADDR  = 9'h002,
        LBC_ST_AACK  = 9'h004,
        LBC_ST_PTR   = 9'h008,
        LBC_ST_PACK  = 9'h010,
        LBC_ST_WDATA = 9'h020,
        LBC_ST_WACK  = 9'h040,
        LBC_ST_RDATA = 9'h080,
        LBC_ST_RACK  = 9'h100
    } lbc_state_t;

endpackage : lbc_pkg

// file: design/lbc_edge.sv
// Edge detector for one sampled serial line
`timescale 1ns/1ps
module lbc_edge (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic line_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import lbc_pkg::*;

    logic line_q;
    logic line_d;

    // ------------------------------------------------------------
    // Previous level
    // ------------------------------------------------------------
    always_comb begin
        line_d = line_in;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            line_q <= 1'b1;
        end else begin
            line_q <= line_d;
        end
    end

    assign level = line_in;
    assign rise  = line_in & ~line_q;
    assign fall  = ~line_in & line_q;

endmodule : lbc_edge

// file: design/lbc_ovp.sv
// Over-voltage threshold decode and string-top comparison
`timescale 1ns/1ps
module lbc_ovp (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [5:0]            ovp_threshold_code,
    input  wire logic [11:0]           string_top_sense,
    output logic      [11:0]           threshold_q,
    output logic                       over_q,
    output logic                       limit_q
);
    import lbc_pkg::*;

    logic [11:0] threshold_d;
    logic        over_d;
    logic        limit_d;
    logic [11:0] coarse;
    logic [11:0] fine;

    // ------------------------------------------------------------
    // Threshold decode and compare
    // ------------------------------------------------------------
    always_comb begin
        coarse = 12'({10'h000, ovp_threshold_code[LBC_OVP_COARSE_HI:LBC_OVP_COARSE_LO]});
        fine   = 12'({9'h000, ovp_threshold_code[LBC_OVP_FINE_HI:0]});
        if (ovp_threshold_code[LBC_OVP_RANGE]) begin
            threshold_d = 12'(LBC_HI_BASE + coarse * LBC_HI_COARSE + fine * LBC_HI_FINE);
        end else begin
            threshold_d = 12'(LBC_LO_BASE + coarse * LBC_LO_COARSE + fine * LBC_LO_FINE);
        end
        over_d  = string_top_sense > threshold_d;
        limit_d = string_top_sense >= threshold_d;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            threshold_q <= 12'h000;
            over_q      <= 1'b0;
            limit_q     <= 1'b0;
        end else begin
            threshold_q <= threshold_d;
            over_q      <= over_d;
            limit_q     <= limit_d;
        end
    end

endmodule : lbc_ovp

// file: dv/lbc_host.sv
// Two-wire serial host model driving the register bank
`timescale 1ns/1ps
module lbc_host (
    input  logic clk,
    input  logic sda_in,
    output logic scl,
    output logic sda_low
);
    import lbc_pkg::*;

    initial begin
        scl     <= 1'b1;
        sda_low <= 1'b0;
    end

    // ------------------------------------------------------------
    // Bus phases: clock moves first, data one clock later
    // ------------------------------------------------------------
    task automatic phase(input logic s, input logic d);
        scl <= s;
        @(posedge clk);
        sda_low <= !d;
        repeat (3) @(posedge clk);
    endtask : phase

    task automatic start_bit();
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
    endtask : start_bit

    task automatic stop_bit();
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : stop_bit

    task automatic send(input logic [7:0] b, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            phase(1'b0, b[i]);
            phase(1'b1, b[i]);
        end
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        nack = sda_in;
    endtask : send

    task automatic recv(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            phase(1'b0, 1'b1);
            phase(1'b1, 1'b1);
            b[i] = sda_in;
        end
        phase(1'b0, last);
        phase(1'b1, last);
    endtask : recv

    // ------------------------------------------------------------
    // Register transfers with pointer auto-increment
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] sa, input logic [7:0] ptr, input logic [7:0] d[$],
                      output logic nack);
        logic n;
        start_bit();
        send({sa, 1'b0}, nack);
        if (!nack) begin
            send(ptr, n);
            foreach (d[i]) send(d[i], n);
        end
        stop_bit();
    endtask : wr

    task automatic rd(input logic [7:0] ptr, input int cnt, output logic [7:0] q[$]);
        logic       n;
        logic [7:0] b;
        q = {};
        start_bit();
        send({LBC_SLAVE_ADDR, 1'b0}, n);
        send(ptr, n);
        start_bit();
        send({LBC_SLAVE_ADDR, 1'b1}, n);
        for (int i = 0; i < cnt; i++) begin
            recv(i == cnt - 1, b);
            q.push_back(b);
        end
        stop_bit();
    endtask : rd
endmodule : lbc_host

// file: dv/lbc_assertions.sv
// Concurrent checks on the ports of the LED boost control register bank
`timescale 1ns/1ps
module lbc_assertions (
    input logic        clk,
    input logic        rst_b,
    input logic        scl_in,
    input logic        sda_in,
    input logic        sda_out,
    input logic        sda_oe_b,
    input logic        pushbutton_in_n,
    input logic        regulator_enable_pin,
    input logic [11:0] string_top_sense,
    input logic        led_boost_regulator_en,
    input logic        overvoltage_protection,
    input logic [11:0] ovp_threshold_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic thr_ok;
    always_comb begin
        thr_ok = (ovp_threshold_q >= 12'h1f4 && ovp_threshold_q <= 12'h4fb &&
                  (ovp_threshold_q - 12'h1f4) % 12'h019 == 12'h000) ||
                 (ovp_threshold_q >= 12'h514 && ovp_threshold_q <= 12'hb22 &&
                  (ovp_threshold_q - 12'h514) % 12'h032 == 12'h000);
    end

    property p_en_pb;
        !pushbutton_in_n |=> led_boost_regulator_en;
    endproperty
    property p_en_off;
        pushbutton_in_n && !regulator_enable_pin |=> !led_boost_regulator_en;
    endproperty
    property p_limit_hi;
        (string_top_sense >= ovp_threshold_q) [*3] |-> overvoltage_protection;
    endproperty
    property p_limit_lo;
        (string_top_sense < ovp_threshold_q) [*3] |-> !overvoltage_protection;
    endproperty
    property p_thr_rst;
        $rose(rst_b) |-> ##[1:2] ovp_threshold_q == 12'hb22;
    endproperty
    property p_thr_valid;
        rst_b [*3] |-> thr_ok;
    endproperty
    property p_thr_hold;
        scl_in [*6] |-> $stable(ovp_threshold_q);
    endproperty
    property p_sda_fall;
        $fell(sda_oe_b) |-> !scl_in;
    endproperty

    a_en_pb:     assert property (p_en_pb) else $error("enable missed on pushbutton");
    a_en_off:    assert property (p_en_off) else $error("enable without cause");
    a_limit_hi:  assert property (p_limit_hi) else $error("limit missing");
    a_limit_lo:  assert property (p_limit_lo) else $error("limit spurious");
    a_thr_rst:   assert property (p_thr_rst) else $error("threshold not at top");
    a_thr_valid: assert property (p_thr_valid) else $error("threshold off table");
    a_thr_hold:  assert property (p_thr_hold) else $error("threshold moved in idle");
    a_sda_fall:  assert property (p_sda_fall) else $error("data driven in clock high");

    c_en_pin: cover property (regulator_enable_pin && pushbutton_in_n ##1 led_boost_regulator_en);
    c_ack:    cover property ($fell(sda_oe_b));
    c_limit:  cover property ($rose(overvoltage_protection));
endmodule : lbc_assertions

// file: dv/lbc_test.sv
// Testbench top for the LED boost control register bank
`timescale 1ns/1ps
module lbc_test;
    import lbc_pkg::*;
    logic        clk;
    logic        rst_b;
    logic        scl;
    logic        host_low;
    logic        sda_w;
    logic        sda_out;
    logic        sda_oe_b;
    logic        pushbutton_in_n;
    logic        regulator_enable_pin;
    logic [11:0] string_top_sense;
    logic        led_boost_regulator_en;
    logic        overvoltage_protection;
    logic [11:0] ovp_threshold_q;
    logic        nack;
    logic [5:0]  codes[$] = {6'h0b, 6'h1d, 6'h27, 6'h3e, 6'h00};
    int          n_errors = 0;
    int          comparisons = 0;

    // Open-drain data line with pull-up
    assign sda_w = (sda_oe_b ? 1'b1 : sda_out) & !host_low;

    lbc_top uut (.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_b(sda_oe_b), .pushbutton_in_n(pushbutton_in_n),
        .regulator_enable_pin(regulator_enable_pin), .string_top_sense(string_top_sense),
        .led_boost_regulator_en(led_boost_regulator_en),
        .overvoltage_protection(overvoltage_protection), .ovp_threshold_q(ovp_threshold_q));

    lbc_host host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_low(host_low));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp[$]);
        logic [7:0] got[$];
        host.rd(ptr, exp.size(), got);
        foreach (exp[i]) check("register byte", {4'h0, exp[i]}, {4'h0, got[i]});
    endtask : rd_chk

    task automatic en_chk(input logic on);
        for (int i = 0; i < 4; i++) begin
            pushbutton_in_n      <= i[0];
            regulator_enable_pin <= i[1];
            repeat (3) @(posedge clk);
            check("regulator enable", {11'h0, !i[0] | (i[1] & on)},
                  {11'h0, led_boost_regulator_en});
        end
    endtask : en_chk

    function automatic logic [11:0] thr_of(input logic [5:0] c);
        return c[5] ? 12'h514 + 12'h190 * c[4:3] + 12'h032 * c[2:0]
                    : 12'h1f4 + 12'h0c8 * c[4:3] + 12'h019 * c[2:0];
    endfunction : thr_of

    task automatic finish_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        rst_b                <= 1'b0;
        pushbutton_in_n      <= 1'b1;
        regulator_enable_pin <= 1'b0;
        string_top_sense     <= 12'h000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("threshold", 12'hb22, ovp_threshold_q);
        rd_chk(LBC_ADDR_RSVD_A, {8'h00, 8'h00, 8'h02, 8'h3f});
        host.wr(LBC_SLAVE_ADDR, LBC_ADDR_ENABLE, {8'hf9, 8'hff}, nack);
        check("ack", 12'h000, {11'h0, nack});
        rd_chk(LBC_ADDR_ENABLE, {8'h03, 8'h3f});
        en_chk(1'b1);
        host.wr(LBC_SLAVE_ADDR, LBC_ADDR_ENABLE, {8'h00}, nack);
        en_chk(1'b0);
        foreach (codes[i]) begin
            host.wr(LBC_SLAVE_ADDR, LBC_ADDR_OVP, {8'hc0 | {2'b00, codes[i]}}, nack);
            repeat (3) @(posedge clk);
            check("threshold", thr_of(codes[i]), ovp_threshold_q);
            rd_chk(LBC_ADDR_OVP, {{2'b00, codes[i]}});
        end
        for (int i = 0; i < 3; i++) begin
            string_top_sense <= 12'h1f3 + i[11:0];
            repeat (4) @(posedge clk);
            check("limit", {11'h0, i > 0}, {11'h0, overvoltage_protection});
            rd_chk(LBC_ADDR_ENABLE, {{6'h00, i < 2, 1'b0}});
        end
        string_top_sense <= 12'h000;
        host.wr(LBC_SLAVE_ADDR ^ 7'h01, LBC_ADDR_OVP, {8'h05}, nack);
        check("ack refused", 12'h001, {11'h0, nack});
        host.wr(LBC_SLAVE_ADDR, LBC_ADDR_RSVD_A, {8'hff, 8'hff}, nack);
        rd_chk(LBC_ADDR_RSVD_A, {8'h00, 8'h00, 8'h02, 8'h00});
        rd_chk(LBC_ADDR_OVP + 8'h01, {LBC_UNMAPPED_VAL});
        rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("threshold", 12'hb22, ovp_threshold_q);
        rd_chk(LBC_ADDR_ENABLE, {8'h02, 8'h3f});
        finish_test();
    end
endmodule : lbc_test

bind lbc_top lbc_assertions chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .pushbutton_in_n(pushbutton_in_n),
    .regulator_enable_pin(regulator_enable_pin), .string_top_sense(string_top_sense),
    .led_boost_regulator_en(led_boost_regulator_en),
    .overvoltage_protection(overvoltage_protection), .ovp_threshold_q(ovp_threshold_q));
